// File: logic/cmc_comparator_ctrl.sv
// Comparator input mux, response mode and edge interrupt control
`timescale 1ns/10ps
module cmc_comparator_ctrl #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // Special-function-register port
  input  wire logic [7:0]             sfr_addr_i,
  input  wire logic                   sfr_wr_i,
  input  wire logic [7:0]             sfr_wdata_i,
  input  wire logic                   sfr_rd_i,
  output logic [7:0]                  sfr_rdata_o,
  output logic                        sfr_hit_o,
  // Analog core side
  input  wire logic                   cmp_out_i,
  output logic [3:0]                  negative_input_select_o,
  output logic                        negative_input_valid_o,
  output logic [3:0]                  positive_input_select_o,
  output logic                        positive_input_valid_o,
  output cmc_pkg::cmc_resp_mode_t     response_mode_o,
  output logic                        cmp_level_o,
  // Edge flags and their software clears
  input  wire logic                   rise_flag_clear_i,
  input  wire logic                   fall_flag_clear_i,
  output logic                        rise_edge_flag_o,
  output logic                        fall_edge_flag_o,
  // Interrupt handler side
  input  wire logic                   system_comparator_irq_enable_i,
  output logic                        cmp_irq_req_o,
  output logic                        cmp_irq_o
);
  import cmc_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Highest honoured code; the small variant wires only the first three pins per side
  localparam logic [3:0] SEL_MAX = LARGE_VARIANT ? CMC_SEL_MAX_LARGE : CMC_SEL_MAX_SMALL;

  // Select code honoured for this variant; shared by both muxes
  function automatic logic sel_ok(input logic [3:0] code);
    sel_ok = (code <= SEL_MAX);
  endfunction : sel_ok

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]     comparator_input_select;
  logic [7:0]     comparator_mode_select;
  logic           rise_edge_flag;
  logic           fall_edge_flag;
  logic [7:0]     rdata;
  logic           hit;
  logic [3:0]     neg_sel;
  logic           neg_ok;
  logic [3:0]     pos_sel;
  logic           pos_ok;
  logic           irq_req;
  logic           irq;
  logic [7:0]     next_comparator_input_select;
  logic [7:0]     next_comparator_mode_select;
  logic           next_rise_edge_flag;
  logic           next_fall_edge_flag;
  logic [7:0]     next_rdata;
  logic           next_hit;
  logic [3:0]     next_neg_sel;
  logic           next_neg_ok;
  logic [3:0]     next_pos_sel;
  logic           next_pos_ok;
  logic           next_irq_req;
  logic           next_irq;
  logic           sync_level;
  logic           sync_rise;
  logic           sync_fall;
  logic           rise_ie;
  logic           fall_ie;

  // Comparator output is asynchronous to the core clock
  cmc_edge_sync u_edge_sync (
    .clk_i     (core_clk_i),
    .rst_i     (rst_i),
    .cmp_raw_i (cmp_out_i),
    .level_o   (sync_level),
    .rise_o    (sync_rise),
    .fall_o    (sync_fall)
  );

  assign rise_ie = comparator_mode_select[CMC_RISE_IE_BIT];
  assign fall_ie = comparator_mode_select[CMC_FALL_IE_BIT];

  // ****************************************************************
  // Register writes and reads
  // ****************************************************************
  always_comb begin
    next_comparator_input_select = comparator_input_select;
    next_comparator_mode_select  = comparator_mode_select;
    next_rdata                   = 8'h00;
    next_hit                     = 1'b0;
    if (sfr_wr_i) begin
      if (sfr_addr_i == CMC_INPUT_SELECT_ADDR) begin
        next_comparator_input_select = sfr_wdata_i;
      end
      if (sfr_addr_i == CMC_MODE_SELECT_ADDR) begin
        // Dead bits never stored, so they always read zero; the reserved
        // top bit is dropped the same way, software writes it as zero
        next_comparator_mode_select = sfr_wdata_i & CMC_MODE_LIVE_MASK;
      end
    end
    // Unmapped addresses answer zero with no hit
    // A read and a write in one cycle return the old contents, since the
    // read samples the register before the write lands
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        CMC_INPUT_SELECT_ADDR: begin
          next_rdata = comparator_input_select;
          next_hit   = 1'b1;
        end
        CMC_MODE_SELECT_ADDR: begin
          next_rdata = comparator_mode_select & CMC_MODE_LIVE_MASK;
          next_hit   = 1'b1;
        end
        default: begin
          next_rdata = 8'h00;
          next_hit   = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Mux selects to the analog core
  // ****************************************************************
  always_comb begin
    // Codes outside the variant's range drop the valid; the analog mux
    // then leaves the input unconnected rather than aliasing a pin
    // Registered once more so select and valid reach the switch together
    next_neg_sel = comparator_input_select[CMC_NEG_SEL_LSB +: CMC_SEL_W];
    next_pos_sel = comparator_input_select[CMC_POS_SEL_LSB +: CMC_SEL_W];
    next_neg_ok  = sel_ok(next_neg_sel);
    next_pos_ok  = sel_ok(next_pos_sel);
  end

  // ****************************************************************
  // Edge flags and interrupt request
  // ****************************************************************
  always_comb begin
    // Set beats a clear landing in the same cycle, so an edge that
    // arrives while software clears is never lost
    // A reset while the comparator reads high shows up as a rising edge
    // once the chain refills; software clears it after start-up
    next_rise_edge_flag = sync_rise | (rise_edge_flag & ~rise_flag_clear_i);
    next_fall_edge_flag = sync_fall | (fall_edge_flag & ~fall_flag_clear_i);
    // Request follows flag state one cycle later, held while true
    next_irq_req = (rise_edge_flag & rise_ie) | (fall_edge_flag & fall_ie);
    next_irq     = next_irq_req & system_comparator_irq_enable_i;
  end

  // Registers only
  // Reset values give the power-up state: inputs 7/7, response mode 2
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      comparator_input_select <= CMC_INPUT_SELECT_RST;
      comparator_mode_select  <= CMC_MODE_SELECT_RST;
      rise_edge_flag          <= 1'b0;
      fall_edge_flag          <= 1'b0;
      rdata                   <= 8'h00;
      hit                     <= 1'b0;
      neg_sel                 <= CMC_INPUT_SELECT_RST[CMC_NEG_SEL_LSB +: CMC_SEL_W];
      pos_sel                 <= CMC_INPUT_SELECT_RST[CMC_POS_SEL_LSB +: CMC_SEL_W];
      neg_ok                  <= 1'b0;
      pos_ok                  <= 1'b0;
      irq_req                 <= 1'b0;
      irq                     <= 1'b0;
    end else begin
      comparator_input_select <= next_comparator_input_select;
      comparator_mode_select  <= next_comparator_mode_select;
      rise_edge_flag          <= next_rise_edge_flag;
      fall_edge_flag          <= next_fall_edge_flag;
      rdata                   <= next_rdata;
      hit                     <= next_hit;
      neg_sel                 <= next_neg_sel;
      pos_sel                 <= next_pos_sel;
      neg_ok                  <= next_neg_ok;
      pos_ok                  <= next_pos_ok;
      irq_req                 <= next_irq_req;
      irq                     <= next_irq;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign sfr_rdata_o             = rdata;
  assign sfr_hit_o               = hit;
  assign negative_input_select_o = neg_sel;
  assign negative_input_valid_o  = neg_ok;
  assign positive_input_select_o = pos_sel;
  assign positive_input_valid_o  = pos_ok;
  // Mode comes straight from the stored field; the analog core follows
  // it one edge after the write, with no extra pipeline stage
  assign response_mode_o         = cmc_resp_mode_t'(
    comparator_mode_select[CMC_RESP_MODE_LSB +: CMC_RESP_MODE_W]);
  assign cmp_level_o             = sync_level;
  assign rise_edge_flag_o        = rise_edge_flag;
  assign fall_edge_flag_o        = fall_edge_flag;
  assign cmp_irq_req_o           = irq_req;
  assign cmp_irq_o               = irq;

endmodule : cmc_comparator_ctrl

// File: logic/cmc_edge_sync.sv
// Synchroniser and edge detector for the asynchronous comparator output
`timescale 1ns/10ps
module cmc_edge_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Raw comparator level
  input  wire logic cmp_raw_i,
  // Filtered level and edge pulses
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  import cmc_pkg::*;

  logic [2:0] sync;
  logic       level;
  logic       rise;
  logic       fall;
  logic [2:0] next_sync;
  logic       next_level;
  logic       next_rise;
  logic       next_fall;

  // ****************************************************************
  // Three-stage capture; stage 0 feeds only stage 1
  // ****************************************************************
  always_comb begin
    next_sync  = {sync[1:0], cmp_raw_i};
    next_level = level;
    next_rise  = 1'b0;
    next_fall  = 1'b0;
    // Change accepted only when stages 1 and 2 agree
    if ((sync[1] == sync[2]) && (sync[2] != level)) begin
      next_level = sync[2];
      next_rise  = sync[2];
      next_fall  = ~sync[2];
    end
  end

  // Registers only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync  <= 3'h0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      sync  <= next_sync;
      level <= next_level;
      rise  <= next_rise;
      fall  <= next_fall;
    end
  end

  assign level_o = level;
  assign rise_o  = rise;
  assign fall_o  = fall;

endmodule : cmc_edge_sync

// File: logic/cmc_pkg.sv
// Package: register map, field layout, reset values and modes for comparator control
package cmc_pkg;

  // ****************************************************************
  // Register offsets in the special-function-register space
  // ****************************************************************
  localparam logic [7:0] CMC_MODE_SELECT_ADDR  = 8'h9d;
  localparam logic [7:0] CMC_INPUT_SELECT_ADDR = 8'h9f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMC_NEG_SEL_LSB   = 4;
  localparam int CMC_POS_SEL_LSB   = 0;
  localparam int CMC_SEL_W         = 4;
  localparam int CMC_RISE_IE_BIT   = 5;
  localparam int CMC_FALL_IE_BIT   = 4;
  localparam int CMC_RESP_MODE_LSB = 0;
  localparam int CMC_RESP_MODE_W   = 2;

  // Bits of the mode register that hold state; all others read zero
  localparam logic [7:0] CMC_MODE_LIVE_MASK = 8'h33;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CMC_MODE_SELECT_RST  = 8'h02;
  localparam logic [7:0] CMC_INPUT_SELECT_RST = 8'h77;

  // ****************************************************************
  // Select code limits per package variant
  // ****************************************************************
  localparam logic [3:0] CMC_SEL_MAX_LARGE = 4'h7;
  localparam logic [3:0] CMC_SEL_MAX_SMALL = 4'h2;

  // Response-time modes, fastest to lowest power
  typedef enum logic [1:0] {
    CMC_RESP_FASTEST = 2'h0,
    CMC_RESP_FAST    = 2'h1,
    CMC_RESP_SLOW    = 2'h2,
    CMC_RESP_LOWPWR  = 2'h3
  } cmc_resp_mode_t;

endpackage : cmc_pkg

// File: verification/cmc_cmp_model.sv
// Behavioural model of the analog comparator core feeding the block
`timescale 1ns/10ps
module cmc_cmp_model #(
  parameter int RESP_NS = 120
) (
  // Requested result and chosen response mode
  input  wire logic       level_i,
  input  wire logic [1:0] mode_i,
  // Raw asynchronous output
  output logic            cmp_out_o
);
  // Slower modes answer later, so the bench must not assume a fixed lag
  initial cmp_out_o = 1'b0;
  always @(level_i) cmp_out_o <= #(RESP_NS * (mode_i + 1)) level_i;
endmodule : cmc_cmp_model

// File: verification/cmc_ctrl_props.sv
// Checker: concurrent properties on the comparator control ports
`timescale 1ns/10ps
module cmc_ctrl_props
  import cmc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock, reset and register port
  input wire logic           core_clk_i,
  input wire logic           rst_i,
  input wire logic [7:0]     sfr_addr_i,
  input wire logic           sfr_wr_i,
  input wire logic [7:0]     sfr_wdata_i,
  input wire logic           sfr_rd_i,
  input wire logic [7:0]     sfr_rdata_o,
  input wire logic           sfr_hit_o,
  // Mux and mode outputs
  input wire logic [3:0]     negative_input_select_o,
  input wire logic [3:0]     positive_input_select_o,
  input wire logic           positive_input_valid_o,
  input wire cmc_resp_mode_t response_mode_o,
  // Edge flags and requests
  input wire logic           cmp_level_o,
  input wire logic           rise_flag_clear_i,
  input wire logic           rise_edge_flag_o,
  input wire logic           fall_edge_flag_o,
  input wire logic           system_comparator_irq_enable_i,
  input wire logic           cmp_irq_req_o,
  input wire logic           cmp_irq_o
);
  localparam logic [3:0] SEL_MAX = LARGE_VARIANT ? CMC_SEL_MAX_LARGE : CMC_SEL_MAX_SMALL;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // Register access steps
  // ****************************************************************
  sequence s_wr_input; sfr_wr_i && sfr_addr_i == CMC_INPUT_SELECT_ADDR; endsequence
  sequence s_wr_mode; sfr_wr_i && sfr_addr_i == CMC_MODE_SELECT_ADDR; endsequence
  sequence s_rd_mode; sfr_rd_i && sfr_addr_i == CMC_MODE_SELECT_ADDR; endsequence
  sequence s_rd_other;
    sfr_rd_i && sfr_addr_i != CMC_MODE_SELECT_ADDR && sfr_addr_i != CMC_INPUT_SELECT_ADDR;
  endsequence
  a_neg_sel_track: assert property (s_wr_input |-> ##2
    negative_input_select_o == $past(sfr_wdata_i[7:4], 2)) else $error("neg select lost");
  // First edge after reset still shows the reset valid level
  a_pos_valid_code: assert property (!$past(rst_i) |->
    positive_input_valid_o == (positive_input_select_o <= SEL_MAX)) else $error("bad valid");
  a_mode_read_mask: assert property (s_rd_mode |=> sfr_hit_o &&
    (sfr_rdata_o & 8'hcc) == 8'h00 && sfr_rdata_o[1:0] == $past(response_mode_o))
    else $error("mode read wrong");
  a_unmapped_read: assert property (s_rd_other |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read answered");
  a_resp_mode_write: assert property (s_wr_mode |=>
    response_mode_o == $past(sfr_wdata_i[1:0])) else $error("response mode not written");
  // Level and edge pulse change on one edge; the flag follows one edge later
  a_rise_sets_flag: assert property ($rose(cmp_level_o) |=> rise_edge_flag_o)
    else $error("rise flag missed");
  a_fall_sets_flag: assert property ($fell(cmp_level_o) |=> fall_edge_flag_o)
    else $error("fall flag missed");
  a_rise_flag_sticky: assert property (rise_edge_flag_o && !rise_flag_clear_i |=>
    rise_edge_flag_o) else $error("rise flag dropped");
  a_no_flag_no_req: assert property (!rise_edge_flag_o && !fall_edge_flag_o |=>
    !cmp_irq_req_o) else $error("request without flag");
  a_irq_sys_gate: assert property (!system_comparator_irq_enable_i |=> !cmp_irq_o)
    else $error("irq without system enable");
endmodule : cmc_ctrl_props

bind cmc_comparator_ctrl cmc_ctrl_props #(.LARGE_VARIANT(LARGE_VARIANT)) props_u (
  .core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o,
  .sfr_hit_o, .negative_input_select_o, .positive_input_select_o, .positive_input_valid_o,
  .response_mode_o, .cmp_level_o, .rise_flag_clear_i, .rise_edge_flag_o, .fall_edge_flag_o,
  .system_comparator_irq_enable_i, .cmp_irq_req_o, .cmp_irq_o);

// File: verification/tb.sv
// Testbench: register, mux select and edge interrupt scenarios
`timescale 1ns/10ps
module tb;
  import cmc_pkg::*;
  logic           core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, rise_clr, fall_clr, sys_ie, level;
  logic [7:0]     sfr_addr_i, sfr_wdata_i, rdata, rd_v;
  logic [3:0]     nsel, psel;
  logic           nval, pval, hit, cmp_out, lvl, rflag, fflag, req, irq, rd_h;
  cmc_resp_mode_t rmode;
  int             n_fail, total_checks, cycles;
  cmc_comparator_ctrl dut_u (.core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .sfr_rd_i, .sfr_rdata_o(rdata), .sfr_hit_o(hit), .cmp_out_i(cmp_out),
    .negative_input_select_o(nsel), .negative_input_valid_o(nval),
    .positive_input_select_o(psel), .positive_input_valid_o(pval), .response_mode_o(rmode),
    .cmp_level_o(lvl), .rise_flag_clear_i(rise_clr), .fall_flag_clear_i(fall_clr),
    .rise_edge_flag_o(rflag), .fall_edge_flag_o(fflag),
    .system_comparator_irq_enable_i(sys_ie), .cmp_irq_req_o(req), .cmp_irq_o(irq));
  cmc_cmp_model model_u (.level_i(level), .mode_i(2'(rmode)), .cmp_out_o(cmp_out));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    tick(2);
  endtask : wr
  // Data stands one cycle only, so it is caught at the next falling edge;
  // one more edge passes so a following read never re-raises the strobe at once
  task automatic rd(input logic [7:0] a);
    sfr_addr_i = a;
    sfr_rd_i   = 1'b1;
    tick(1);
    sfr_rd_i = 1'b0;
    rd_v     = rdata;
    rd_h     = hit;
    tick(1);
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(CMC_MODE_SELECT_ADDR);
    chk(rd_v, CMC_MODE_SELECT_RST);
    chk(rd_h, 8'h01);
    rd(CMC_INPUT_SELECT_ADDR);
    chk(rd_v, CMC_INPUT_SELECT_RST);
    chk(nsel, 8'h07);
    chk(psel, 8'h07);
    chk(nval, 8'h01);
    chk(rmode, 8'h02);
  endtask : t_reset
  // Every code on both sides, plus code 8 which no variant maps
  task automatic t_mux;
    for (int c = 0; c <= 8; c++) begin
      wr(CMC_INPUT_SELECT_ADDR, {4'(c), 4'(8 - c)});
      chk(nsel, 8'(c));
      chk(nval, 8'(c <= CMC_SEL_MAX_LARGE));
      chk(psel, 8'(8 - c));
      chk(pval, 8'(c >= 1));
      rd(CMC_INPUT_SELECT_ADDR);
      chk(rd_v, {4'(c), 4'(8 - c)});
    end
  endtask : t_mux
  task automatic t_mode;
    wr(CMC_MODE_SELECT_ADDR, 8'h7f); // Reserved top bit written as zero
    rd(CMC_MODE_SELECT_ADDR);
    chk(rd_v, 8'h33);
    for (int m = 0; m < 4; m++) begin
      wr(CMC_MODE_SELECT_ADDR, 8'(m));
      chk(rmode, 8'(m));
    end
    // Unmapped address between the registers: write dropped, read empty
    wr(8'h9e, 8'hff);
    rd(8'h9e);
    chk(rd_v, 8'h00);
    chk(rd_h, 8'h00);
    rd(CMC_MODE_SELECT_ADDR);
    chk(rd_v, 8'h03);
    rd(CMC_INPUT_SELECT_ADDR);
    chk(rd_v, 8'h80);
  endtask : t_mode
  task automatic t_edges;
    sys_ie = 1'b1; // Software sets both enables
    wr(CMC_MODE_SELECT_ADDR, 8'h32);
    level = 1'b1;
    tick(16);
    chk(lvl, 8'h01);
    chk(rflag, 8'h01);
    chk(fflag, 8'h00);
    chk(req, 8'h01);
    chk(irq, 8'h01);
    tick(20);
    chk(rflag, 8'h01);
    rise_clr = 1'b1; // Software clears its own flag
    tick(1);
    rise_clr = 1'b0;
    tick(3);
    chk(rflag, 8'h00);
    chk(req, 8'h00);
    wr(CMC_MODE_SELECT_ADDR, 8'h22);
    level = 1'b0;
    tick(16);
    chk(lvl, 8'h00);
    chk(fflag, 8'h01);
    chk(req, 8'h00);
    sys_ie = 1'b0;
    wr(CMC_MODE_SELECT_ADDR, 8'h12);
    tick(2);
    chk(req, 8'h01);
    chk(irq, 8'h00);
    fall_clr = 1'b1;
    tick(1);
    fall_clr = 1'b0;
    tick(3);
    chk(fflag, 8'h00);
    chk(req, 8'h00);
    wr(CMC_MODE_SELECT_ADDR, 8'h02);
    level = 1'b1;
    tick(16);
    chk(rflag, 8'h01);
    chk(req, 8'h00);
  endtask : t_edges
  // Reset in mid-run restores the registers while the comparator still reads high
  task automatic t_mid_reset;
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(1);
    chk(rflag, 8'h00);
    chk(lvl, 8'h00);
    chk(nsel, 8'h07);
    rd(CMC_INPUT_SELECT_ADDR);
    chk(rd_v, CMC_INPUT_SELECT_RST);
    tick(6);
    chk(lvl, 8'h01);
  endtask : t_mid_reset
  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    rst_i = 1'b1; sfr_wr_i = 1'b0; sfr_rd_i = 1'b0; sfr_addr_i = 8'h00; sfr_wdata_i = 8'h00;
    rise_clr = 1'b0; fall_clr = 1'b0; sys_ie = 1'b0; level = 1'b0;
    n_fail = 0; total_checks = 0; cycles = 0;
    tick(3);
    rst_i = 1'b0;
    tick(1);
    t_reset();
    t_mux();
    t_mode();
    t_edges();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : tb
